// ==== rtl/ssp_consts.svh ====
`ifndef SSP_CONSTS_SVH
`define SSP_CONSTS_SVH

// ************************************************************
// Byte framing.
// ************************************************************
`define SSP_BYTE_BITS 8
`define SSP_LAST_BIT 4'h8
`define SSP_DATA_RESET 8'h00

// ************************************************************
// Prescaler: half period of the shift clock is 2**rate cycles.
// ************************************************************
`define SSP_RATE_MAX 3'h6
`define SSP_DIV_W 7

`endif

// ==== rtl/ssp_pkg.sv ====
package ssp_pkg;

  typedef enum logic [0:0]
  {
    SSP_IDLE = 1'b0,
    SSP_RUN = 1'b1
  } ssp_state_t;

  typedef logic [7:0] ssp_byte_t;

endpackage

// ==== rtl/ssp_clk_if.sv ====
`timescale 1ns/10ps
`default_nettype none

interface ssp_clk_if;
  logic run;
  logic [2:0] rate;
  logic tick;

  modport gen
  (
    input run,
    input rate,
    output tick
  );

  modport user
  (
    output run,
    output rate,
    input tick
  );
endinterface

`default_nettype wire

// ==== rtl/ssp_clkgen.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.svh"

module ssp_clkgen
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  ssp_clk_if.gen cif
);

  // ************************************************************
  // Half-period divider.
  // ************************************************************
  logic [`SSP_DIV_W-1:0] cnt_reg;
  logic [`SSP_DIV_W-1:0] cnt_next;
  logic [`SSP_DIV_W-1:0] limit;
  logic [2:0] rate_eff;

  always_comb
  begin
    // Code seven has no rate of its own and falls back to the slowest.
    rate_eff = (cif.rate > `SSP_RATE_MAX) ? `SSP_RATE_MAX : cif.rate;
    limit = (`SSP_DIV_W'(1) << rate_eff) - `SSP_DIV_W'(1);
    cif.tick = cif.run && (cnt_reg == limit);
    if (!cif.run || cif.tick)
    begin
      cnt_next = '0;
    end
    else
    begin
      cnt_next = cnt_reg + `SSP_DIV_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= '0;
    end
    else if (ce)
    begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

`default_nettype wire

// ==== rtl/ssp_port.sv ====
// What this block does
// - Runs as master or slave; master starts transfers.
// - Slave's eight-bit shift register forms ring with peer; master fills with zeros, receives into a second register.
// - Bytes shift out most significant bit first.
// - Four modes from clock polarity and phase.
// - Master shapes output clock by polarity only; phase sets just the data edges.
// - Slave accepts asynchronous clock, adjusted by settings.
// - Byte written from bus; receive double buffered.
// - Flags: done, write collision, mode fault.
// - Select pin is always an input.
// - Slave takes part only while selected low.
// - Master with sense enabled: select low faults.
// - Live select level always readable.
// - Pins switchable open-drain or direct drive.
// - Single-wire slave: shared data line, open-drain.
// - Transmit single buffered; receive copied after eight.
// - Data reads zero after reset.
`timescale 1ns/10ps
`default_nettype none
`include "ssp_consts.svh"

module ssp_port
  import ssp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic master_select_bit,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic select_sense_enable,
  input wire logic open_drain_enable,
  input wire logic master_output_drive_enable,
  input wire logic single_wire,
  input wire logic [2:0] rate_sel,
  input wire logic wr_stb,
  input wire logic [7:0] tx_rx_byte_field,
  output logic [7:0] rx_byte,
  input wire logic clr_done,
  input wire logic clr_write_collision_flag,
  input wire logic clr_mode_fault_flag,
  output logic transfer_done_flag,
  output logic write_collision_flag,
  output logic mode_fault_flag,
  output logic select_level,
  output logic busy,
  input wire logic sck_pin_i,
  output logic sck_pin_o,
  output logic sck_pin_oe,
  input wire logic master_out_slave_in_pin_i,
  output logic master_out_slave_in_pin_o,
  output logic master_out_slave_in_pin_oe,
  input wire logic master_in_slave_out_pin_i,
  output logic master_in_slave_out_pin_o,
  output logic master_in_slave_out_pin_oe,
  input wire logic select_n_pin
);

  // ************************************************************
  // Helpers.
  // ************************************************************
  function automatic ssp_byte_t shift_in(input ssp_byte_t sr, input logic b);
    shift_in = {sr[6:0], b};
  endfunction

  // Returns {level, enable}; open-drain pins only ever pull low.
  function automatic logic [1:0] pin_drive(input logic en, input logic od, input logic v);
    pin_drive = {od ? 1'b0 : v, en & (od ? ~v : 1'b1)};
  endfunction

  function automatic logic write_collision_flag_set_c(input logic m, input ssp_state_t st, input logic [3:0] c,
                                       input logic sel, input logic sense);
    // A write while a byte is moving would corrupt it, so it is dropped.
    if (m)
    begin
      write_collision_flag_set_c = (st == SSP_RUN);
    end
    else
    begin
      write_collision_flag_set_c = (c != 4'h0) || (sense && sel);
    end
  endfunction

  // ************************************************************
  // Input synchronisers.
  // ************************************************************
  // Every pin is asynchronous in slave mode, so all pass two flops.
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] sync1_next;
  logic [3:0] sync2_next;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic sel_n_s;

  always_comb
  begin
    sync1_next = {select_n_pin, master_in_slave_out_pin_i, master_out_slave_in_pin_i, sck_pin_i};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 4'hF;
      sync2_reg <= 4'hF;
    end
    else if (ce)
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign sck_s = sync2_reg[0];
  assign mosi_s = sync2_reg[1];
  assign miso_s = sync2_reg[2];
  assign sel_n_s = sync2_reg[3];
  assign select_level = sel_n_s;

  // ************************************************************
  // Prescaler.
  // ************************************************************
  ssp_clk_if cif();
  ssp_state_t state_reg;
  ssp_state_t state_next;

  assign cif.run = (state_reg == SSP_RUN);
  assign cif.rate = rate_sel;

  ssp_clkgen u_clkgen
  (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .cif(cif)
  );

  // ************************************************************
  // Shift control.
  // ************************************************************
  ssp_byte_t sr_reg;
  ssp_byte_t sr_next;
  ssp_byte_t rx_reg;
  ssp_byte_t rx_next;
  logic samp_reg;
  logic samp_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic phase_reg;
  logic phase_next;
  logic sck_prev_reg;
  logic sck_prev_next;
  logic done_reg;
  logic done_next;
  logic write_collision_flag_reg;
  logic write_collision_flag_next;
  logic mode_fault_flag_reg;
  logic mode_fault_flag_next;
  ssp_byte_t rsh_reg;
  ssp_byte_t rsh_next;
  logic [3:0] mcnt_reg;
  logic [3:0] mcnt_next;
  logic [2:0] mdly_reg;
  logic [2:0] mdly_next;
  logic is_master;
  logic slave_sel;
  logic fault;
  logic lead;
  logic trail;
  logic din;
  logic finish;

  always_comb
  begin
    is_master = enable & master_select_bit;
    slave_sel = enable & ~master_select_bit & ~sel_n_s;
    fault = is_master & select_sense_enable & ~sel_n_s;
    // Slave receives on the out/in line, which in single-wire use is the joined line.
    din = is_master ? miso_s : mosi_s;
    lead = 1'b0;
    trail = 1'b0;
    if (is_master)
    begin
      lead = cif.tick & ~phase_reg;
      trail = cif.tick & phase_reg;
    end
    else if (slave_sel)
    begin
      // Edges are found on the synchronised clock, so a slave's shift clock
      // must run well below a quarter of the system clock.
      lead = (sck_s != clock_polarity_bit) && (sck_prev_reg == clock_polarity_bit);
      trail = (sck_s == clock_polarity_bit) && (sck_prev_reg != clock_polarity_bit);
    end
  end

  always_comb
  begin
    state_next = state_reg;
    sr_next = sr_reg;
    rx_next = rx_reg;
    samp_next = samp_reg;
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    sck_prev_next = sck_s;
    finish = 1'b0;
    if (state_reg == SSP_RUN && cif.tick)
    begin
      phase_next = ~phase_reg;
    end
    if (lead)
    begin
      samp_next = din;
    end
    rsh_next = rsh_reg;
    mcnt_next = mcnt_reg;
    // A master takes each returned bit three cycles after its trailing tick, because the clock
    // pin lags the tick by two flops and the bit comes back through two synchroniser flops.
    mdly_next = {mdly_reg[1:0], trail & is_master};
    if (trail)
    begin
      cnt_next = cnt_reg + 4'h1;
      if (is_master)
      begin
        if (!clock_phase_bit)
        begin
          sr_next = shift_in(sr_reg, 1'b0);
        end
        if (cnt_reg + 4'h1 == `SSP_LAST_BIT)
        begin
          cnt_next = 4'h0;
          state_next = SSP_IDLE;
        end
      end
      else
      begin
        // Phase zero samples on the leading edge; phase one on the trailing edge.
        sr_next = shift_in(sr_reg, clock_phase_bit ? din : samp_reg);
        if (cnt_reg + 4'h1 == `SSP_LAST_BIT)
        begin
          finish = 1'b1;
          cnt_next = 4'h0;
          rx_next = shift_in(sr_reg, clock_phase_bit ? din : samp_reg);
        end
      end
    end
    if (lead && is_master && clock_phase_bit && cnt_reg != 4'h0)
    begin
      // In phase one the next bit goes out on the leading edge.
      sr_next = shift_in(sr_reg, 1'b0);
    end
    if (mdly_reg[2])
    begin
      rsh_next = shift_in(rsh_reg, din);
      mcnt_next = mcnt_reg + 4'h1;
      if (mcnt_reg + 4'h1 == `SSP_LAST_BIT)
      begin
        finish = 1'b1;
        mcnt_next = 4'h0;
        rx_next = shift_in(rsh_reg, din);
      end
    end
    if (!is_master && !slave_sel)
    begin
      cnt_next = 4'h0;
    end
    if (fault || !is_master)
    begin
      mdly_next = 3'h0;
      mcnt_next = 4'h0;
      if (state_reg == SSP_RUN)
      begin
        state_next = SSP_IDLE;
        phase_next = 1'b0;
        cnt_next = 4'h0;
      end
    end
    if (wr_stb && !write_collision_flag_set_c(is_master, state_reg, cnt_reg, slave_sel, select_sense_enable))
    begin
      // The transmit byte goes straight into the shift register.
      sr_next = tx_rx_byte_field;
      if (is_master && !fault && !mode_fault_flag_reg && mdly_reg == 3'h0 && mcnt_reg == 4'h0)
      begin
        state_next = SSP_RUN;
        phase_next = 1'b0;
        cnt_next = 4'h0;
      end
    end
  end

  always_comb
  begin
    // A new event wins over a clear in the same cycle.
    done_next = finish | (done_reg & ~clr_done);
    write_collision_flag_next = (wr_stb & ~is_master & write_collision_flag_set_c(is_master, state_reg, cnt_reg, slave_sel,
                  select_sense_enable)) | (write_collision_flag_reg & ~clr_write_collision_flag);
    mode_fault_flag_next = fault | (mode_fault_flag_reg & ~clr_mode_fault_flag);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= SSP_IDLE;
      sr_reg <= `SSP_DATA_RESET;
      rx_reg <= `SSP_DATA_RESET;
      samp_reg <= 1'b0;
      cnt_reg <= 4'h0;
      phase_reg <= 1'b0;
      sck_prev_reg <= 1'b1;
      done_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      mode_fault_flag_reg <= 1'b0;
      rsh_reg <= `SSP_DATA_RESET;
      mcnt_reg <= 4'h0;
      mdly_reg <= 3'h0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      sr_reg <= sr_next;
      rx_reg <= rx_next;
      samp_reg <= samp_next;
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      sck_prev_reg <= sck_prev_next;
      done_reg <= done_next;
      write_collision_flag_reg <= write_collision_flag_next;
      mode_fault_flag_reg <= mode_fault_flag_next;
      rsh_reg <= rsh_next;
      mcnt_reg <= mcnt_next;
      mdly_reg <= mdly_next;
    end
  end

  assign rx_byte = rx_reg;
  assign transfer_done_flag = done_reg;
  assign write_collision_flag = write_collision_flag_reg;
  assign mode_fault_flag = mode_fault_flag_reg;
  assign busy = (state_reg == SSP_RUN) || (cnt_reg != 4'h0) || (mdly_reg != 3'h0) || (mcnt_reg != 4'h0);

  // ************************************************************
  // Pin control.
  // ************************************************************
  logic [5:0] pin_reg;
  logic [5:0] pin_next;
  logic od;
  logic m_drive;
  logic [1:0] sck_d;
  logic [1:0] mosi_d;
  logic [1:0] miso_d;

  always_comb
  begin
    od = open_drain_enable | single_wire;
    // A faulted master lets go of the shared lines to end the contention.
    m_drive = is_master & master_output_drive_enable & ~mode_fault_flag_reg;
    sck_d = pin_drive(m_drive, od, clock_polarity_bit ^ phase_reg);
    mosi_d = pin_drive(m_drive, od, sr_reg[7]);
    miso_d = pin_drive(slave_sel, od, sr_reg[7]);
    if (single_wire)
    begin
      mosi_d = pin_drive(m_drive, 1'b1, sr_reg[7]);
    end
    pin_next = {sck_d, mosi_d, miso_d};
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_reg <= 6'h00;
    end
    else if (ce)
    begin
      pin_reg <= pin_next;
    end
  end

  assign sck_pin_o = pin_reg[5];
  assign sck_pin_oe = pin_reg[4];
  assign master_out_slave_in_pin_o = pin_reg[3];
  assign master_out_slave_in_pin_oe = pin_reg[2];
  assign master_in_slave_out_pin_o = pin_reg[1];
  assign master_in_slave_out_pin_oe = pin_reg[0];

endmodule

`default_nettype wire

// ==== tb/ssp_peer_slave.sv ====
`timescale 1ns/10ps
`default_nettype none

// ********
// Far-side slave unit.
// ********
module ssp_peer_slave
(
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [7:0] tx,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sh = 8'h00;
  logic bit_q = 1'b1;
  wire logic lead = sck ^ cpol;

  // A released line floats up to its pull-up level.
  assign miso = sel_n ? 1'b1 : bit_q;
  always @(negedge sel_n)
  begin
    sh = tx;
    bit_q = tx[7];
  end
  always @(lead)
  begin
    if (!sel_n && (lead ^ cpha))
      rx = {rx[6:0], mosi};
    else if (!sel_n)
    begin
      if (cpha)
        bit_q = sh[7];
      sh = sh << 1;
      if (!cpha)
        bit_q = sh[7];
    end
  end
endmodule

`default_nettype wire

// ==== tb/ssp_port_checker.sv ====
`timescale 1ns/10ps
`default_nettype none

// ********
// Port checker.
// ********
module ssp_port_checker
(
  input wire logic clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic master_select_bit,
  input wire logic select_sense_enable,
  input wire logic [2:0] rate_sel,
  input wire logic wr_stb,
  input wire logic transfer_done_flag,
  input wire logic write_collision_flag,
  input wire logic mode_fault_flag,
  input wire logic select_level,
  input wire logic busy,
  input wire logic select_n_pin,
  input wire logic sck_pin_oe,
  input wire logic master_out_slave_in_pin_oe,
  input wire logic master_in_slave_out_pin_oe
);
  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Only the fastest rate is timed here; slower rates are timed by the bench.
  sequence m_start;
    wr_stb && enable && master_select_bit && !busy && !mode_fault_flag && select_n_pin && rate_sel == 3'h0 &&
      !transfer_done_flag;
  endsequence
  sequence m_shift_done;
    ##1 !transfer_done_flag [*8] ##[10:12] transfer_done_flag;
  endsequence

  a_done_time: assert property (m_start |-> m_shift_done)
    else $error("done timing wrong");
  a_fault_raise: assert property (enable && master_select_bit && select_sense_enable && !select_level |-> ##[0:3]
    mode_fault_flag)
    else $error("mode fault missing");
  a_fault_cause: assert property ($rose(mode_fault_flag) |-> $past(master_select_bit) && $past(select_sense_enable))
    else $error("mode fault without cause");
  a_select_live: assert property (select_level == $past(select_n_pin, 2))
    else $error("select level stale");
  a_slave_quiet: assert property (!master_select_bit && !$past(master_select_bit) |-> !sck_pin_oe &&
    !master_out_slave_in_pin_oe)
    else $error("slave drives master pins");
  a_master_no_miso: assert property (master_select_bit && $past(master_select_bit) |-> !master_in_slave_out_pin_oe)
    else $error("master drives input line");
  a_unsel_quiet: assert property (!master_select_bit && select_level && $past(select_level) |->
    !master_in_slave_out_pin_oe)
    else $error("unselected slave drives");
  a_write_collision_flag_set: assert property (!master_select_bit && enable && busy && wr_stb |=> write_collision_flag)
    else $error("collision not flagged");
endmodule

bind ssp_port ssp_port_checker chk_u (.*);

`default_nettype wire

// ==== tb/ssp_port_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; $display("CHECK FAILED %0t %s", $time, m); end end

// ********
// Bench.
// ********
module ssp_port_tb_top
  import ssp_pkg::*;
;
  logic clk = 0, rst = 1, ce = 1, enable = 0, master_select_bit = 1, clock_polarity_bit = 0, clock_phase_bit = 0;
  logic select_sense_enable = 0, open_drain_enable = 0, master_output_drive_enable = 1, single_wire = 0;
  logic wr_stb = 0, clr_done = 0, clr_write_collision_flag = 0, clr_mode_fault_flag = 0, select_n_pin = 1, psel_n = 1, m_sck = 0, m_mosi = 1;
  logic [2:0] rate_sel = 3'h0;
  ssp_byte_t tx_rx_byte_field = 8'h00, ptx = 8'h00, rx_byte, prx, cap;
  logic transfer_done_flag, write_collision_flag, mode_fault_flag, select_level, busy, pmiso;
  logic sck_pin_o, sck_pin_oe, master_out_slave_in_pin_o, master_out_slave_in_pin_oe;
  logic master_in_slave_out_pin_o, master_in_slave_out_pin_oe;
  wire logic sck_pin_i = sck_pin_oe ? sck_pin_o : m_sck;
  wire logic master_out_slave_in_pin_i = master_out_slave_in_pin_oe ? master_out_slave_in_pin_o : m_mosi;
  wire logic master_in_slave_out_pin_i = master_in_slave_out_pin_oe ? master_in_slave_out_pin_o : pmiso;
  int n_mismatch = 0, n_checks = 0, cyc = 0;

  always #5 clk = ~clk;

  ssp_port dut_u (.*);
  ssp_peer_slave peer_u (.sck(sck_pin_i), .mosi(master_out_slave_in_pin_i), .sel_n(psel_n), .cpol(clock_polarity_bit),
    .cpha(clock_phase_bit), .tx(ptx), .miso(pmiso), .rx(prx));

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A second write lands mid-byte and must be ignored.
  task automatic mxfer(input ssp_byte_t d, input ssp_byte_t p, input logic [2:0] r);
    int n = 0;
    repeat (2) @(posedge clk);
    rate_sel <= r;
    ptx <= p;
    psel_n <= 0;
    @(posedge clk);
    wr_stb <= 1;
    tx_rx_byte_field <= d;
    while (transfer_done_flag !== 1'b1 && n < 1100)
    begin
      @(posedge clk);
      n++;
      wr_stb <= (n == 4);
      tx_rx_byte_field <= ~d;
    end
    `CHK(n >= (16 << r) + 5 && n <= (16 << r) + 7, 1'b1, "done timing")
    `CHK(rx_byte, p, "master rx")
    `CHK(prx, d, "peer rx")
    psel_n <= 1;
    clr_done <= 1;
    @(posedge clk);
    clr_done <= 0;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 0;
    enable <= 1;
    @(posedge clk);
    `CHK(rx_byte, 8'h00, "reset data")
    for (int m = 0; m < 4; m++)
    begin
      clock_polarity_bit <= m[1];
      clock_phase_bit <= m[0];
      mxfer(8'hc3, 8'h5a ^ 8'(m), (m == 3) ? 3'h6 : 3'(m));
    end
    $display("test 1 done");
    select_n_pin <= 0;
    repeat (4) @(posedge clk);
    `CHK(mode_fault_flag, 1'b0, "fault without sense")
    `CHK(select_level, 1'b0, "live select")
    select_sense_enable <= 1;
    repeat (4) @(posedge clk);
    `CHK(mode_fault_flag, 1'b1, "fault")
    `CHK(master_out_slave_in_pin_oe, 1'b0, "pins released")
    wr_stb <= 1;
    @(posedge clk);
    wr_stb <= 0;
    select_n_pin <= 1;
    select_sense_enable <= 0;
    repeat (3) @(posedge clk);
    `CHK(busy, 1'b0, "start blocked")
    clr_mode_fault_flag <= 1;
    @(posedge clk);
    clr_mode_fault_flag <= 0;
    repeat (2) @(posedge clk);
    `CHK(mode_fault_flag, 1'b0, "fault cleared")
    $display("test 2 done");
    master_select_bit <= 0;
    clock_polarity_bit <= 0;
    clock_phase_bit <= 0;
    tx_rx_byte_field <= 8'ha5;
    repeat (3) @(posedge clk);
    wr_stb <= 1;
    @(posedge clk);
    wr_stb <= 0;
    tx_rx_byte_field <= 8'h0f;
    select_n_pin <= 0;
    repeat (6) @(posedge clk);
    for (int i = 7; i >= 0; i--)
    begin
      m_mosi <= i[0] ^ (i > 1) ^ (i > 5);
      repeat (8) @(posedge clk);
      m_sck <= 1;
      cap = {cap[6:0], master_in_slave_out_pin_i};
      wr_stb <= (i == 4);
      @(posedge clk);
      wr_stb <= 0;
      repeat (7) @(posedge clk);
      m_sck <= 0;
    end
    repeat (8) @(posedge clk);
    `CHK(transfer_done_flag, 1'b1, "slave done")
    `CHK(rx_byte, 8'h96, "slave rx")
    `CHK(cap, 8'ha5, "slave tx")
    `CHK(write_collision_flag, 1'b1, "collision")
    select_n_pin <= 1;
    repeat (4) @(posedge clk);
    `CHK(master_in_slave_out_pin_oe, 1'b0, "slave released")
    $display("test 3 done");
    conclude();
  end
endmodule

`default_nettype wire
